// [core/dss_sequencer.sv]
// Host-side start-up, sync and transmit-enable sequencer for a quad DAC
// Notes on behaviour
// - Hold chip reset low at least 25 ns before any register programming.
// - After programming, set fuse sleep bit 11 of configuration register 27.
// - Dual channel: clear register 1 bit 8, write 11b to register 16 bits 13:12.
// - Set clock divider sync enable, register 0 bit 2, before sync pulses.
// - PLL multi-device sync: set register 24 bit 11 before sync.
// - Start all link signals together, then issue sync edges.
// - Single sync source mode uses one rising edge, not periodic sync.
// - Dual sync sources mode accepts single pulse or periodic sync.
// - In PLL mode the link sync input resets the PLL N-divider.
// - Single source mode: clear divider sync enable before transmitting.
// - Dual sources mode: divider sync enable may stay set.
// - Optionally zero FIFO pointer selects and set formatter select to 10b.
// - After initial sync, clear PLL N-divider sync enable bit.
// - Device outputs data only while transmission is enabled.
// - On alarm drop transmit gate and redo sync configuration onward.
// - Clear alarm status by writing zero, then read it back.
`timescale 1ns/1ps
`default_nettype none

module dss_sequencer #(
    parameter int unsigned SYNC_HIGH_CYC = dss_pkg::SYNC_HIGH_CYC
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  ce,
    input  wire logic [7:0]            sw_addr,
    input  wire logic [15:0]           sw_wdata,
    input  wire logic                  sw_wr,
    input  wire logic                  sw_rd,
    output logic      [15:0]           sw_rdata,
    output dss_pkg::dss_sif_cmd_t      sif_cmd,
    output logic                       sif_valid,
    input  wire logic                  sif_done,
    input  wire logic [15:0]           sif_rdata,
    input  wire logic                  alarm_pin,
    output logic                       chip_reset_n,
    output logic                       link_run,
    output logic                       frame_strobe_lvds,
    output logic                       align_strobe_lvds,
    output logic                       tx_gate
);

    // =========================================================
    // Software registers
    // =========================================================
    logic [4:0]  mode_q;
    logic [15:0] cfg0_q, cfg1_q, cfg16_q, cfg24_q, cfg27_q, cfg31_q, cfg32_q;
    logic [15:0] alm_q;
    logic        done_q, fail_q;
    logic        start_w, stop_w;
    dss_pkg::dss_state_t state_q;

    wire dual_sync = mode_q[dss_pkg::CTRL_DUALSYNC-1];
    wire pll_sync  = mode_q[dss_pkg::CTRL_PLLSYNC-1];
    wire dual_ch   = mode_q[dss_pkg::CTRL_DUALCH-1];
    wire fifo_off  = mode_q[dss_pkg::CTRL_FIFOOFF-1];

    assign start_w = ce && sw_wr && sw_addr == dss_pkg::REG_CTRL
                     && sw_wdata[dss_pkg::CTRL_START];
    assign stop_w  = ce && sw_wr && sw_addr == dss_pkg::REG_CTRL
                     && sw_wdata[dss_pkg::CTRL_STOP];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_q  <= dss_pkg::RST_MODE;
            cfg0_q  <= dss_pkg::RST_CFG0;
            cfg1_q  <= dss_pkg::RST_CFG1;
            cfg16_q <= dss_pkg::RST_OTHER;
            cfg24_q <= dss_pkg::RST_OTHER;
            cfg27_q <= dss_pkg::RST_OTHER;
            cfg31_q <= dss_pkg::RST_OTHER;
            cfg32_q <= dss_pkg::RST_OTHER;
        end else if (ce && sw_wr) begin
            case (sw_addr)
                dss_pkg::REG_CTRL:  mode_q  <= sw_wdata[5:1];
                dss_pkg::REG_CFG0:  cfg0_q  <= sw_wdata;
                dss_pkg::REG_CFG1:  cfg1_q  <= sw_wdata;
                dss_pkg::REG_CFG16: cfg16_q <= sw_wdata;
                dss_pkg::REG_CFG24: cfg24_q <= sw_wdata;
                dss_pkg::REG_CFG27: cfg27_q <= sw_wdata;
                dss_pkg::REG_CFG31: cfg31_q <= sw_wdata;
                dss_pkg::REG_CFG32: cfg32_q <= sw_wdata;
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sw_rdata <= 16'h0000;
        end else if (ce) begin
            sw_rdata <= 16'h0000;
            if (sw_rd) begin
                case (sw_addr)
                    dss_pkg::REG_CTRL:   sw_rdata <= {10'h000, mode_q, 1'b0};
                    dss_pkg::REG_STATUS: sw_rdata <= {state_q, 1'b0, tx_gate,
                                                      link_run, chip_reset_n,
                                                      fail_q, done_q};
                    dss_pkg::REG_CFG0:   sw_rdata <= cfg0_q;
                    dss_pkg::REG_CFG1:   sw_rdata <= cfg1_q;
                    dss_pkg::REG_CFG16:  sw_rdata <= cfg16_q;
                    dss_pkg::REG_CFG24:  sw_rdata <= cfg24_q;
                    dss_pkg::REG_CFG27:  sw_rdata <= cfg27_q;
                    dss_pkg::REG_CFG31:  sw_rdata <= cfg31_q;
                    dss_pkg::REG_CFG32:  sw_rdata <= cfg32_q;
                    dss_pkg::REG_ALMRD:  sw_rdata <= alm_q;
                    default:             sw_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // =========================================================
    // Alarm pin synchroniser
    // =========================================================
    logic alarm_m_q, alarm_s_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            alarm_m_q <= 1'b0;
            alarm_s_q <= 1'b0;
        end else if (ce) begin
            alarm_m_q <= alarm_pin;
            alarm_s_q <= alarm_m_q;
        end
    end

    // =========================================================
    // Access list: what each step writes or reads
    // =========================================================
    logic [3:0] idx_q;
    dss_pkg::dss_sif_cmd_t entry;

    always_comb begin
        entry = '{rd: 1'b0, addr: dss_pkg::DEV_ALARM_STAT,
                  data: dss_pkg::ALARM_CLEAR};
        case (idx_q)
            4'h0: begin
                entry.addr = dss_pkg::DEV_CFG1;
                entry.data = cfg1_q;
                if (dual_ch)
                    entry.data[dss_pkg::QUAD_BIT] = 1'b0;
            end
            4'h1: begin
                entry.addr = dss_pkg::DEV_CFG16;
                entry.data = cfg16_q;
                if (dual_ch)
                    entry.data[dss_pkg::DUALCH_LSB +: 2] =
                        dss_pkg::DUALCH_CODE;
            end
            4'h2: begin
                entry.addr = dss_pkg::DEV_CFG27;
                entry.data = cfg27_q;
                entry.data[dss_pkg::FUSE_SLEEP_BIT] = 1'b1;
            end
            4'h3: begin
                entry.addr = dss_pkg::DEV_ALIGN_CTRL;
                entry.data = cfg31_q;
            end
            4'h4: begin
                entry.addr = dss_pkg::DEV_ALIGN_SEL;
                entry.data = cfg32_q;
            end
            4'h5: begin
                entry.addr = dss_pkg::DEV_MAIN_CTRL;
                entry.data = cfg0_q;
                entry.data[dss_pkg::CLKDIV_ENA_BIT] = 1'b1;
            end
            4'h6: begin
                entry.addr = dss_pkg::DEV_PLL_CTRL;
                entry.data = cfg24_q;
                entry.data[dss_pkg::NDIV_SYNC_BIT] = pll_sync;
            end
            4'h7: begin
                entry.addr = dss_pkg::DEV_ALARM_STAT;
                entry.data = dss_pkg::ALARM_CLEAR;
            end
            4'h8: begin
                entry.rd   = 1'b1;
                entry.addr = dss_pkg::DEV_ALARM_STAT;
            end
            4'h9: begin
                entry.addr = dss_pkg::DEV_MAIN_CTRL;
                entry.data = cfg0_q;
                entry.data[dss_pkg::CLKDIV_ENA_BIT] = dual_sync;
            end
            4'ha: begin
                entry.addr = dss_pkg::DEV_ALIGN_SEL;
                entry.data = cfg32_q;
                if (fifo_off) begin
                    entry.data[dss_pkg::FIFOIN_LSB +: 4] =
                        dss_pkg::FIFO_SYNC_OFF;
                    entry.data[dss_pkg::FIFOOUT_LSB +: 4] =
                        dss_pkg::FIFO_SYNC_OFF;
                end
            end
            4'hb: begin
                entry.addr = dss_pkg::DEV_ALIGN_CTRL;
                entry.data = cfg31_q;
                if (fifo_off)
                    entry.data[dss_pkg::FMT_LSB +: 2] =
                        dss_pkg::FMT_SYNC_OFF;
            end
            4'hc: begin
                entry.addr = dss_pkg::DEV_PLL_CTRL;
                entry.data = cfg24_q;
                entry.data[dss_pkg::NDIV_SYNC_BIT] = 1'b0;
            end
            default: ;
        endcase
    end

    // =========================================================
    // Sequencer
    // =========================================================
    logic [4:0] cnt_q;
    wire access_st = state_q == dss_pkg::ST_PROG
                  || state_q == dss_pkg::ST_CHECK
                  || state_q == dss_pkg::ST_DIS;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= dss_pkg::ST_IDLE;
            idx_q   <= dss_pkg::IDX_FIRST;
            cnt_q   <= 5'h00;
        end else if (ce) begin
            cnt_q <= cnt_q + 5'h01;
            if (stop_w) begin
                state_q <= dss_pkg::ST_IDLE;
            end else begin
                case (state_q)
                    dss_pkg::ST_IDLE, dss_pkg::ST_FAIL: begin
                        cnt_q <= 5'h00;
                        idx_q <= dss_pkg::IDX_FIRST;
                        if (start_w)
                            state_q <= dss_pkg::ST_RSTLO;
                    end
                    dss_pkg::ST_RSTLO: begin
                        if (cnt_q == 5'(dss_pkg::RESET_LOW_CYC - 1)) begin
                            cnt_q   <= 5'h00;
                            state_q <= dss_pkg::ST_RSTHI;
                        end
                    end
                    dss_pkg::ST_RSTHI: begin
                        if (cnt_q == 5'(dss_pkg::RESET_REC_CYC - 1))
                            state_q <= dss_pkg::ST_PROG;
                    end
                    dss_pkg::ST_PROG: begin
                        if (sif_done) begin
                            idx_q <= idx_q + 4'h1;
                            if (idx_q == dss_pkg::IDX_PROG_END) begin
                                cnt_q   <= 5'h00;
                                state_q <= dss_pkg::ST_LVDS;
                            end
                        end
                    end
                    dss_pkg::ST_LVDS: begin
                        if (cnt_q == 5'(dss_pkg::LVDS_SETTLE_CYC - 1)) begin
                            cnt_q   <= 5'h00;
                            state_q <= dss_pkg::ST_EDGE;
                        end
                    end
                    dss_pkg::ST_EDGE: begin
                        if (cnt_q == 5'(SYNC_HIGH_CYC - 1))
                            state_q <= dss_pkg::ST_CHECK;
                    end
                    dss_pkg::ST_CHECK: begin
                        if (sif_done) begin
                            idx_q <= idx_q + 4'h1;
                            if (idx_q == dss_pkg::IDX_READ)
                                state_q <= (sif_rdata == 16'h0000)
                                         ? dss_pkg::ST_DIS
                                         : dss_pkg::ST_FAIL;
                        end
                    end
                    dss_pkg::ST_DIS: begin
                        if (sif_done) begin
                            idx_q <= idx_q + 4'h1;
                            if (idx_q == dss_pkg::IDX_DIS_END)
                                state_q <= dss_pkg::ST_RUN;
                        end
                    end
                    dss_pkg::ST_RUN: begin
                        if (alarm_s_q) begin
                            idx_q   <= dss_pkg::IDX_RESYNC;
                            state_q <= dss_pkg::ST_PROG;
                        end
                    end
                    default: state_q <= dss_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Captured alarm read-back and completion flags; set wins over clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            alm_q  <= 16'h0000;
            done_q <= 1'b0;
            fail_q <= 1'b0;
        end else if (ce) begin
            if (start_w) begin
                done_q <= 1'b0;
                fail_q <= 1'b0;
            end
            if (state_q == dss_pkg::ST_CHECK && sif_done
                && idx_q == dss_pkg::IDX_READ) begin
                alm_q <= sif_rdata;
                if (sif_rdata != 16'h0000)
                    fail_q <= 1'b1;
            end
            if (state_q == dss_pkg::ST_DIS && sif_done
                && idx_q == dss_pkg::IDX_DIS_END)
                done_q <= 1'b1;
        end
    end

    // =========================================================
    // Pin and command outputs
    // =========================================================
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            chip_reset_n      <= 1'b1;
            link_run          <= 1'b0;
            frame_strobe_lvds <= 1'b0;
            align_strobe_lvds <= 1'b0;
            tx_gate           <= 1'b0;
            sif_cmd           <= '0;
            sif_valid         <= 1'b0;
        end else if (ce) begin
            chip_reset_n      <= !(start_w && state_q inside
                                   {dss_pkg::ST_IDLE, dss_pkg::ST_FAIL})
                                 && !(state_q == dss_pkg::ST_RSTLO
                                      && cnt_q !=
                                      5'(dss_pkg::RESET_LOW_CYC - 1));
            link_run          <= !(state_q == dss_pkg::ST_IDLE
                                   || state_q == dss_pkg::ST_FAIL
                                   || state_q == dss_pkg::ST_RSTLO
                                   || state_q == dss_pkg::ST_RSTHI
                                   || stop_w);
            frame_strobe_lvds <= (state_q == dss_pkg::ST_LVDS
                                  && cnt_q == 5'(dss_pkg::LVDS_SETTLE_CYC - 1))
                              || (state_q == dss_pkg::ST_EDGE
                                  && cnt_q != 5'(SYNC_HIGH_CYC - 1));
            align_strobe_lvds <= (state_q == dss_pkg::ST_LVDS
                                  && cnt_q == 5'(dss_pkg::LVDS_SETTLE_CYC - 1))
                              || (state_q == dss_pkg::ST_EDGE
                                  && cnt_q != 5'(SYNC_HIGH_CYC - 1));
            tx_gate           <= (state_q == dss_pkg::ST_RUN && !alarm_s_q
                                  && !stop_w)
                              || (state_q == dss_pkg::ST_DIS && sif_done
                                  && idx_q == dss_pkg::IDX_DIS_END
                                  && !stop_w);
            sif_cmd           <= entry;
            sif_valid         <= access_st && !sif_done && !sif_valid
                                 && !stop_w
                              || (sif_valid && !sif_done && !stop_w);
        end
    end

endmodule : dss_sequencer

`default_nettype wire

// [core/dss_pkg.sv]
// Constants, layouts and types shared by the start-up and sync sequencer
package dss_pkg;

    // =========================================================
    // Timing
    // =========================================================
    localparam int unsigned CLK_PERIOD_PS   = 25000;
    localparam int unsigned RESET_LOW_PS    = 25000;
    localparam int unsigned RESET_LOW_RAW   =
        (RESET_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RESET_LOW_CYC   =
        (RESET_LOW_RAW < 1) ? 1 : RESET_LOW_RAW;
    localparam int unsigned RESET_REC_CYC   = 8;
    localparam int unsigned LVDS_SETTLE_CYC = 16;
    localparam int unsigned SYNC_HIGH_CYC   = 4;

    // =========================================================
    // Device register addresses (serial interface)
    // =========================================================
    localparam logic [6:0] DEV_MAIN_CTRL   = 7'h00;
    localparam logic [6:0] DEV_CFG1        = 7'h01;
    localparam logic [6:0] DEV_ALARM_STAT  = 7'h05;
    localparam logic [6:0] DEV_CFG16       = 7'h10;
    localparam logic [6:0] DEV_PLL_CTRL    = 7'h18;
    localparam logic [6:0] DEV_CFG27       = 7'h1b;
    localparam logic [6:0] DEV_ALIGN_CTRL  = 7'h1f;
    localparam logic [6:0] DEV_ALIGN_SEL   = 7'h20;

    // Device field positions and codes
    localparam int unsigned CLKDIV_ENA_BIT  = 2;
    localparam int unsigned QUAD_BIT        = 8;
    localparam int unsigned DUALCH_LSB      = 12;
    localparam int unsigned FUSE_SLEEP_BIT  = 11;
    localparam int unsigned NDIV_SYNC_BIT   = 11;
    localparam int unsigned FIFOIN_LSB      = 12;
    localparam int unsigned FIFOOUT_LSB     = 8;
    localparam int unsigned FMT_LSB         = 2;
    localparam logic [1:0]  DUALCH_CODE     = 2'h3;
    localparam logic [3:0]  FIFO_SYNC_OFF   = 4'h0;
    localparam logic [1:0]  FMT_SYNC_OFF    = 2'h2;
    localparam logic [15:0] ALARM_CLEAR     = 16'h0000;

    // =========================================================
    // Controller register map (byte addresses)
    // =========================================================
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CFG0   = 8'h08;
    localparam logic [7:0] REG_CFG1   = 8'h0c;
    localparam logic [7:0] REG_CFG27  = 8'h10;
    localparam logic [7:0] REG_CFG31  = 8'h14;
    localparam logic [7:0] REG_CFG32  = 8'h18;
    localparam logic [7:0] REG_CFG24  = 8'h1c;
    localparam logic [7:0] REG_ALMRD  = 8'h20;
    localparam logic [7:0] REG_CFG16  = 8'h24;

    // Control register bits
    localparam int unsigned CTRL_START    = 0;
    localparam int unsigned CTRL_DUALSYNC = 1;
    localparam int unsigned CTRL_PLLSYNC  = 2;
    localparam int unsigned CTRL_DUALCH   = 3;
    localparam int unsigned CTRL_FIFOOFF  = 4;
    localparam int unsigned CTRL_STOP     = 5;

    // Reset values of the image registers
    localparam logic [15:0] RST_CFG0  = 16'h049c;
    localparam logic [15:0] RST_CFG1  = 16'h050e;
    localparam logic [15:0] RST_OTHER = 16'h0000;
    localparam logic [4:0]  RST_MODE  = 5'h00;

    // Access list indices
    localparam logic [3:0] IDX_FIRST    = 4'h0;
    localparam logic [3:0] IDX_RESYNC   = 4'h3;
    localparam logic [3:0] IDX_PROG_END = 4'h6;
    localparam logic [3:0] IDX_CLR      = 4'h7;
    localparam logic [3:0] IDX_READ     = 4'h8;
    localparam logic [3:0] IDX_DIS_END  = 4'hc;

    typedef struct packed {
        logic        rd;
        logic [6:0]  addr;
        logic [15:0] data;
    } dss_sif_cmd_t;

    typedef enum logic [9:0] {
        ST_IDLE  = 10'b0000000001,
        ST_RSTLO = 10'b0000000010,
        ST_RSTHI = 10'b0000000100,
        ST_PROG  = 10'b0000001000,
        ST_LVDS  = 10'b0000010000,
        ST_EDGE  = 10'b0000100000,
        ST_CHECK = 10'b0001000000,
        ST_DIS   = 10'b0010000000,
        ST_RUN   = 10'b0100000000,
        ST_FAIL  = 10'b1000000000
    } dss_state_t;

endpackage : dss_pkg

// [testbench/dss_sequencer_chk.sv]
// Port checker for the start-up and sync sequencer
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer_chk #(
    parameter int unsigned SYNC_HIGH_CYC = 4
) (
    input wire logic        clk_sys, reset, ce, sw_rd, sif_valid,
    input wire logic        sif_done, alarm_pin, chip_reset_n, link_run,
    input wire logic        frame_strobe_lvds, align_strobe_lvds, tx_gate,
    input wire logic [15:0] sw_rdata,
    input wire dss_pkg::dss_sif_cmd_t sif_cmd
);
    int unsigned hi_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // =========================================================
    // Strobe length counter
    always_ff @(posedge clk_sys)
        hi_q <= (reset || !align_strobe_lvds) ? 0 : hi_q + 1;
    sif_hold_a: assert property (sif_valid && !sif_done |=>
        sif_valid && $stable(sif_cmd)) else $error("access not held");
    sif_gap_a: assert property (sif_valid && sif_done |=> !sif_valid)
        else $error("access held past answer");
    rd_zero_a: assert property (!sw_rd |=> sw_rdata == 16'h0000)
        else $error("read data outside read slot");
    strobe_len_a: assert property ($fell(align_strobe_lvds) |->
        hi_q == SYNC_HIGH_CYC) else $error("strobe length wrong");
    strobe_pair_a: assert property (frame_strobe_lvds == align_strobe_lvds)
        else $error("strobes not together");
    strobe_link_a: assert property (align_strobe_lvds |-> link_run)
        else $error("strobe without link");
    reset_quiet_a: assert property (!chip_reset_n |->
        !sif_valid && !link_run) else $error("activity in reset");
    alarm_drop_a: assert property ((ce && alarm_pin)[*4] |-> !tx_gate)
        else $error("transmit kept on alarm");
    tx_link_a: assert property (tx_gate |-> link_run && !align_strobe_lvds)
        else $error("transmit without link");
    tx_after_a: assert property ($rose(tx_gate) |->
        $past(sif_done) && !sif_valid) else $error("transmit too early");
    cover property ($rose(tx_gate));
    cover property ($rose(align_strobe_lvds));
    cover property ($fell(tx_gate) && alarm_pin);
endmodule : dss_sequencer_chk
bind dss_sequencer dss_sequencer_chk #(.SYNC_HIGH_CYC(SYNC_HIGH_CYC)) chk_i (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .sw_rd(sw_rd),
    .sif_valid(sif_valid), .sif_done(sif_done), .alarm_pin(alarm_pin),
    .chip_reset_n(chip_reset_n), .link_run(link_run), .tx_gate(tx_gate),
    .frame_strobe_lvds(frame_strobe_lvds), .sw_rdata(sw_rdata),
    .align_strobe_lvds(align_strobe_lvds), .sif_cmd(sif_cmd));
`default_nettype wire

// [testbench/dss_dev_model.sv]
// Behavioural device: register words, access answers, alarm word
`timescale 1ns/1ps
`default_nettype none
module dss_dev_model (
    input  wire logic                  clk_sys,
    input  wire dss_pkg::dss_sif_cmd_t sif_cmd,
    input  wire logic                  sif_valid,
    input  wire logic                  fault,
    input  wire logic                  align_strobe_lvds,
    output logic                       sif_done,
    output logic [15:0]                sif_rdata
);
    logic [15:0] regs [128];
    logic        slow_q = 1'b0;
    logic        strb_q = 1'b0;
    logic        div_armed = 1'b0;
    logic        ndiv_armed = 1'b0;
    initial begin
        sif_done = 1'b0;
        sif_rdata = 16'h0000;
    end
    // =========================================================
    // Access engine: answers on every second cycle that a request waits
    always @(posedge clk_sys) begin
        sif_done <= 1'b0;
        sif_rdata <= ~sif_rdata;
        strb_q <= align_strobe_lvds;
        if (sif_valid && !sif_done) begin
            slow_q <= !slow_q;
            if (slow_q && !sif_cmd.rd) begin
                sif_done <= 1'b1;
                regs[sif_cmd.addr] <= sif_cmd.data;
            end else if (slow_q) begin
                sif_done <= 1'b1;
                sif_rdata <= (sif_cmd.addr != 7'h05) ? regs[sif_cmd.addr]
                           : (fault ? 16'h2000 : 16'h0000);
            end
        end
        if (align_strobe_lvds && !strb_q) begin
            div_armed <= regs[0][2];
            ndiv_armed <= regs[24][11];
        end
    end
endmodule : dss_dev_model
`default_nettype wire

// [testbench/dss_sequencer_tb.sv]
// Self-checking bench for the start-up and sync sequencer
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer_tb;
    logic                  clk_sys = 1'b0;
    logic                  reset = 1'b1;
    logic [7:0]            sw_addr = 8'h00;
    logic [15:0]           sw_wdata = 16'h0000;
    logic                  sw_wr = 1'b0, sw_rd = 1'b0;
    logic                  alarm_pin = 1'b0, fault = 1'b0;
    logic [15:0]           sw_rdata, sif_rdata, rv;
    logic                  sif_valid, sif_done, chip_reset_n, link_run;
    logic                  frame_strobe_lvds, align_strobe_lvds, tx_gate;
    dss_pkg::dss_sif_cmd_t sif_cmd;
    logic [40:0]           rows [8];
    logic [22:0]           post [7];
    int                    mismatches = 0, n_checks = 0;
    always #12.5 clk_sys = !clk_sys;
    dss_sequencer uut (.clk_sys(clk_sys), .reset(reset), .ce(1'b1),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .sif_cmd(sif_cmd), .sif_valid(sif_valid),
        .sif_done(sif_done), .sif_rdata(sif_rdata), .alarm_pin(alarm_pin),
        .chip_reset_n(chip_reset_n), .link_run(link_run), .tx_gate(tx_gate),
        .frame_strobe_lvds(frame_strobe_lvds),
        .align_strobe_lvds(align_strobe_lvds));
    dss_dev_model dev (.clk_sys(clk_sys), .sif_cmd(sif_cmd), .fault(fault),
        .sif_valid(sif_valid), .align_strobe_lvds(align_strobe_lvds),
        .sif_done(sif_done), .sif_rdata(sif_rdata));
    // =========================================================
    // Bus cycles, comparison and verdict
    task automatic chk(input string nm, input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
        @(posedge clk_sys);
    endtask : rd
    task automatic wait_st(input int b);
        logic [15:0] s;
        for (int i = 0; i < 3000; i++) begin
            rd(dss_pkg::REG_STATUS, s);
            if (s[b] === 1'b1) return;
        end
        chk("status wait", 16'h0000, 16'h0001);
    endtask : wait_st
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        report_and_stop();
    end
    // =========================================================
    // Main sequence
    initial begin
        rows = '{{1'b0, 8'h08, 16'h0, 16'h049c}, {1'b0, 8'h0c, 16'h0, 16'h050e},
            {1'b0, 8'h04, 16'h0, 16'h0044}, {1'b1, 8'h18, 16'h2401, 16'h2401},
            {1'b1, 8'h14, 16'h4440, 16'h4440}, {1'b1, 8'h1c, 16'h2c58, 16'h2c58},
            {1'b1, 8'h30, 16'h1234, 16'h0}, {1'b1, 8'h04, 16'hffff, 16'h0044}};
        post = '{{7'h01, 16'h040e}, {7'h10, 16'h3000}, {7'h1b, 16'h0800},
            {7'h00, 16'h0498}, {7'h20, 16'h0001}, {7'h1f, 16'h4448},
            {7'h18, 16'h2458}};
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            if (rows[i][40]) wr(rows[i][39:32], rows[i][31:16]);
            rd(rows[i][39:32], rv);
            chk("register", rv, rows[i][15:0]);
        end
        wr(dss_pkg::REG_CTRL, 16'h001d);
        wait_st(4);
        foreach (post[i])
            chk("device word", dev.regs[post[i][22:16]], post[i][15:0]);
        chk("armed", {14'h0, dev.div_armed, dev.ndiv_armed}, 16'h3);
        rd(dss_pkg::REG_ALMRD, rv);
        chk("alarm word", rv, 16'h0000);
        alarm_pin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("tx on alarm", {15'h0, tx_gate}, 16'h0000);
        alarm_pin <= 1'b0;
        wait_st(4);
        wr(dss_pkg::REG_CTRL, 16'h0020);
        fault <= 1'b1;
        wr(dss_pkg::REG_CTRL, 16'h0001);
        wait_st(1);
        chk("tx on fail", {15'h0, tx_gate}, 16'h0000);
        rd(dss_pkg::REG_ALMRD, rv);
        chk("alarm word", rv, 16'h2000);
        fault <= 1'b0;
        wr(dss_pkg::REG_CTRL, 16'h0003);
        wait_st(4);
        chk("dual cfg0", dev.regs[0], 16'h049c);
        chk("quad cfg1", dev.regs[1], 16'h050e);
        chk("armed", {14'h0, dev.div_armed, dev.ndiv_armed}, 16'h2);
        report_and_stop();
    end
endmodule : dss_sequencer_tb
`default_nettype wire
